// [hdl/clkgen_pkg.sv]
// Constants, field layouts and state type of the system clock generator.
package clkgen_pkg;

    // Register addresses in the processor's data space.
    localparam logic [15:0] CPU_CLOCK_CONTROL_ADDR     = 16'hFFFB;
    localparam logic [15:0] CLOCK_DOUBLER_CONTROL_ADDR = 16'hFF6C;

    // Reset values of the two registers.
    localparam logic [7:0] CPU_CLOCK_CONTROL_RST     = 8'h02;
    localparam logic [7:0] CLOCK_DOUBLER_CONTROL_RST = 8'h00;

    // Field positions.
    localparam int CPU_CLOCK_SELECT_LO_POS = 0;
    localparam int CPU_CLOCK_SELECT_HI_POS = 1;
    localparam int DOUBLER_ENABLE_POS      = 0;

    // CPU clock select codes.
    localparam logic [1:0] SEL_FULL    = 2'h0;
    localparam logic [1:0] SEL_HALF    = 2'h1;
    localparam logic [1:0] SEL_QUARTER = 2'h2;
    localparam logic [1:0] SEL_BAD     = 2'h3;

    // Oscillation stabilization time, in system clock periods (2^15).
    localparam int STAB_EXP    = 15;
    localparam int STAB_PERIOD = 2 ** STAB_EXP;

    // Width of the peripheral clock divider chain.
    localparam int PDIV_W = 8;

    // Stabilization, run and standby states of the generator.
    typedef enum logic [1:0] {
        ST_STAB,
        ST_RUN,
        ST_HALT,
        ST_STOP
    } gen_state_t;

endpackage

// [hdl/system_clock_generator.sv]
// System clock generator: CPU clock divider, peripheral divider, standby.
`timescale 1ns/1ps

// Summary of operation
// - Select field picks fx, fx/2, fx/4; 11 prohibited.
// - Reset loads CPU clock control with 02H.
// - Doubler enable gates the 2fx timer clock.
// - Reset clears doubler control to 00H.
// - Clock switch completes within bounded old clocks.
// - Oscillation stopped while reset held low.
// - Stabilization wait 2^15 clocks before execution.
// - Stop instruction halts the system oscillation.
// - Peripheral clocks divide fx, halt with it.
// - Two standby modes: stop and halt.
module system_clock_generator
    import clkgen_pkg::*;
#(
    parameter int STAB_CYCLES = STAB_PERIOD
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic [15:0]       reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    input  wire logic              stop_req,
    input  wire logic              halt_req,
    input  wire logic              wake_req,
    output logic                   osc_run,
    output logic                   cpu_run,
    output logic                   cpu_tick,
    output logic      [PDIV_W-1:0] periph_div,
    output logic                   timer_x2_en
);

    // Last phase of one CPU clock period for a given select code.
    function automatic logic [1:0] last_phase(input logic [1:0] sel);
        case (sel)
            SEL_FULL:    last_phase = 2'h0;
            SEL_HALF:    last_phase = 2'h1;
            default:     last_phase = 2'h3;
        endcase
    endfunction

    // Stabilization counter width, large enough for the default count.
    localparam int STAB_W = $clog2(STAB_PERIOD) + 1;
    localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_CYCLES - 1);

    logic [1:0]        pend_sel_r;
    logic              doubler_r;
    logic [1:0]        active_sel_r;
    logic [1:0]        phase_r;
    logic              cpu_tick_r;
    logic [PDIV_W-1:0] periph_div_r;
    logic              timer_x2_en_r;
    logic              osc_run_r;
    logic              cpu_run_r;
    logic [7:0]        reg_rdata_r;
    logic [STAB_W-1:0] stab_cnt_r;
    gen_state_t        state_r;
    gen_state_t        state_nxt;

    logic wr_cpu_sel;
    logic wr_doubler;

    // Write strobes for the two mapped registers.
    assign wr_cpu_sel = reg_wr && (reg_addr == CPU_CLOCK_CONTROL_ADDR);
    assign wr_doubler = reg_wr && (reg_addr == CLOCK_DOUBLER_CONTROL_ADDR);

    // Requested CPU clock select; the prohibited code is not accepted.
    // Only the select field is stored, so upper bits always read zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_sel_r <= CPU_CLOCK_CONTROL_RST[1:0];
        end else if (wr_cpu_sel &&
                     reg_wdata[CPU_CLOCK_SELECT_HI_POS:
                               CPU_CLOCK_SELECT_LO_POS] != SEL_BAD) begin
            pend_sel_r <= reg_wdata[CPU_CLOCK_SELECT_HI_POS:
                                    CPU_CLOCK_SELECT_LO_POS];
        end
    end

    // Doubler enable; bits above the enable are not stored.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            doubler_r <= CLOCK_DOUBLER_CONTROL_RST[DOUBLER_ENABLE_POS];
        end else if (wr_doubler) begin
            doubler_r <= reg_wdata[DOUBLER_ENABLE_POS];
        end
    end

    // Read data, registered; unmapped addresses read zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == CPU_CLOCK_CONTROL_ADDR) begin
                reg_rdata_r <= {6'h00, pend_sel_r};
            end else if (reg_addr == CLOCK_DOUBLER_CONTROL_ADDR) begin
                reg_rdata_r <= {7'h00, doubler_r};
            end else begin
                reg_rdata_r <= 8'h00;
            end
        end
    end

    // Standby state machine: stabilization, run, halt and stop.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_STAB: begin
                if (stab_cnt_r == STAB_LAST) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_req) begin
                    state_nxt = ST_STOP;
                end else if (halt_req) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake_req) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_STOP: begin
                if (wake_req) begin
                    state_nxt = ST_STAB;
                end
            end
            default: begin
                state_nxt = ST_STAB;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_STAB;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Stabilization counter runs only while waiting after reset or stop.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stab_cnt_r <= '0;
        end else if (state_r == ST_STAB && stab_cnt_r != STAB_LAST) begin
            stab_cnt_r <= stab_cnt_r + STAB_W'(1);
        end else begin
            stab_cnt_r <= '0;
        end
    end

    // Oscillator runs except in reset and in stop mode.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_run_r <= 1'b0;
        end else begin
            osc_run_r <= (state_nxt != ST_STOP);
        end
    end

    // The CPU executes only in run state.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_run_r <= 1'b0;
        end else begin
            cpu_run_r <= (state_nxt == ST_RUN);
        end
    end

    // CPU clock divider. A new select takes effect only when the old
    // period ends, so no phase is shortened and the wait stays within
    // one old CPU clock.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r      <= 2'h0;
            cpu_tick_r   <= 1'b0;
            active_sel_r <= CPU_CLOCK_CONTROL_RST[1:0];
        end else if (osc_run_r) begin
            if (phase_r == last_phase(active_sel_r)) begin
                phase_r      <= 2'h0;
                cpu_tick_r   <= 1'b1;
                active_sel_r <= pend_sel_r;
            end else begin
                phase_r    <= phase_r + 2'h1;
                cpu_tick_r <= 1'b0;
            end
        end else begin
            cpu_tick_r <= 1'b0;
        end
    end

    // Peripheral divider chain counts fx and freezes with the oscillator.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_div_r <= '0;
        end else if (osc_run_r) begin
            periph_div_r <= periph_div_r + PDIV_W'(1);
        end
    end

    // Multiplier enable toward the timer, off one edge after fx turns off.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_x2_en_r <= 1'b0;
        end else begin
            timer_x2_en_r <= doubler_r && osc_run_r;
        end
    end

    assign reg_rdata   = reg_rdata_r;
    assign osc_run     = osc_run_r;
    assign cpu_run     = cpu_run_r;
    assign cpu_tick    = cpu_tick_r;
    assign periph_div  = periph_div_r;
    assign timer_x2_en = timer_x2_en_r;

    // Checks on the generator's own behaviour.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_quarter_start;
        cpu_tick_r && active_sel_r == SEL_QUARTER && osc_run_r;
    endsequence

    sequence s_half_start;
        cpu_tick_r && active_sel_r == SEL_HALF && osc_run_r;
    endsequence

    a_full_rate: assert property (
        (cpu_tick_r && active_sel_r == SEL_FULL && osc_run_r) |=> cpu_tick_r
    ) else $error("full rate CPU clock missed a tick");

    a_half_rate: assert property (
        s_half_start ##1 osc_run_r |=> cpu_tick_r && $past(!cpu_tick_r)
    ) else $error("half rate CPU clock period wrong");

    a_quarter_rate: assert property (
        s_quarter_start ##1 osc_run_r[*3] |=> cpu_tick_r && $past(!cpu_tick_r)
    ) else $error("quarter rate CPU clock period wrong");

    a_bad_code_kept: assert property (
        (wr_cpu_sel && reg_wdata[1:0] == SEL_BAD) |=> $stable(pend_sel_r)
    ) else $error("prohibited select code was accepted");

    a_switch_bound: assert property (
        (pend_sel_r != active_sel_r && osc_run_r)[*4]
        |=> !(pend_sel_r != active_sel_r && osc_run_r)
    ) else $error("CPU clock switch took too long");

    a_switch_boundary: assert property (
        $changed(active_sel_r) |-> cpu_tick_r && phase_r == 2'h0
    ) else $error("CPU clock switched inside a period");

    a_osc_reset: assert property (
        $rose(rst_n) |-> !osc_run_r && !cpu_run_r
    ) else $error("oscillator running during reset");

    a_stab_wait: assert property (
        $rose(cpu_run_r) && $past(state_r) == ST_STAB
        |-> $past(stab_cnt_r) == STAB_LAST && active_sel_r == pend_sel_r
    ) else $error("execution began before stabilization");

    a_stop_osc: assert property (
        (stop_req && state_r == ST_RUN) |=> !osc_run_r [*1] ##1 !cpu_tick_r
    ) else $error("stop did not halt the oscillator");

    a_halt_cpu: assert property (
        (halt_req && !stop_req && state_r == ST_RUN)
        |=> !cpu_run_r && osc_run_r
    ) else $error("halt did not suspend the CPU");

    a_periph_hold: assert property (
        !osc_run_r |=> $stable(periph_div_r)
    ) else $error("peripheral divider moved without fx");

    a_doubler_on: assert property (
        (doubler_r && osc_run_r) |=> timer_x2_en_r
    ) else $error("2fx supply not enabled");

    a_doubler_off: assert property (
        !doubler_r |=> !timer_x2_en_r
    ) else $error("2fx supply not cut off");

endmodule

// [tb/system_clock_generator_test.sv]
// Self-checking testbench of the system clock generator.
`timescale 1ns/1ps
module system_clock_generator_test;
    import clkgen_pkg::*;
    localparam int STAB = 8;
    logic              core_clk;
    logic              rst_n;
    logic [15:0]       reg_addr;
    logic              reg_wr;
    logic              reg_rd;
    logic [7:0]        reg_wdata;
    logic [7:0]        reg_rdata;
    logic              stop_req;
    logic              halt_req;
    logic              wake_req;
    logic              osc_run;
    logic              cpu_run;
    logic              cpu_tick;
    logic [PDIV_W-1:0] periph_div;
    logic              timer_x2_en;
    int                num_errors = 0;
    int                samples_checked = 0;

    // Short stabilization count keeps the run brief.
    system_clock_generator #(.STAB_CYCLES(STAB)) system_clock_generator_i (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .stop_req(stop_req), .halt_req(halt_req),
        .wake_req(wake_req), .osc_run(osc_run), .cpu_run(cpu_run),
        .cpu_tick(cpu_tick), .periph_div(periph_div),
        .timer_x2_en(timer_x2_en));

    // The clock runs at 20 MHz.
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    // Compares one value and counts the outcome.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic final_report;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bus cycles, each entered one edge after the previous one ended.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    // Counts edges until the next CPU tick or until run comes up.
    task automatic next_tick(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (cpu_tick !== 1'b1 && n < 40);
    endtask

    task automatic wait_run(output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (cpu_run !== 1'b1 && n < 40);
    endtask

    // Pulses one standby control input for a single edge.
    task automatic pulse(input int which);
        @(posedge core_clk);
        #1 {stop_req, halt_req, wake_req} = 3'b100 >> which;
        @(posedge core_clk);
        #1 {stop_req, halt_req, wake_req} = 3'b000;
    endtask

    task automatic do_reset;
        int n;
        rst_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 check({7'h0, osc_run}, 8'h00, "osc in reset");
        rst_n = 1'b1;
        wait_run(n);
        check(8'(n >= STAB && n <= STAB + 2), 8'h01, "stab wait");
    endtask

    // Reset values, unmapped read, prohibited code and the doubler.
    task automatic t_regs;
        logic [7:0] d;
        int n;
        rd(CPU_CLOCK_CONTROL_ADDR, d);
        check(d, 8'h02, "cpu ctrl reset");
        rd(CLOCK_DOUBLER_CONTROL_ADDR, d);
        check(d, 8'h00, "doubler reset");
        check({7'h0, timer_x2_en}, 8'h00, "x2 off");
        next_tick(n);
        next_tick(n);
        check(8'(n), 8'h04, "slow period");
        rd(16'h1234, d);
        check(d, 8'h00, "unmapped read");
        wr(CLOCK_DOUBLER_CONTROL_ADDR, 8'h01);
        rd(CLOCK_DOUBLER_CONTROL_ADDR, d);
        check(d, 8'h01, "doubler readback");
        check({7'h0, timer_x2_en}, 8'h01, "x2 on");
        wr(CLOCK_DOUBLER_CONTROL_ADDR, 8'h00);
        // The enable register follows the stored bit one edge later.
        @(posedge core_clk);
        #1 check({7'h0, timer_x2_en}, 8'h00, "x2 off again");
        wr(CPU_CLOCK_CONTROL_ADDR, 8'h02);
        rd(CPU_CLOCK_CONTROL_ADDR, d);
        check(d, 8'h02, "cpu ctrl readback");
        wr(CPU_CLOCK_CONTROL_ADDR, 8'h03);
        rd(CPU_CLOCK_CONTROL_ADDR, d);
        check(d, 8'h02, "prohibited code");
    endtask

    // Walks all six transitions between the three rates.
    task automatic t_select;
        logic [1:0] seq [7] = '{SEL_FULL, SEL_HALF, SEL_QUARTER, SEL_FULL,
                                SEL_QUARTER, SEL_HALF, SEL_FULL};
        logic [7:0] d;
        int n;
        int old_p;
        old_p = 4;
        foreach (seq[i]) begin
            wr(CPU_CLOCK_CONTROL_ADDR, {6'h00, seq[i]});
            next_tick(n);
            check(8'(n <= old_p + (1 << seq[i])), 8'h01, "switch");
            next_tick(n);
            next_tick(n);
            check(8'(n), 8'(1 << seq[i]), "new period");
            rd(CPU_CLOCK_CONTROL_ADDR, d);
            check(d, {6'h00, seq[i]}, "select readback");
            old_p = 1 << seq[i];
        end
    endtask

    // Stop freezes every derived clock until a wake.
    task automatic t_stop;
        logic [PDIV_W-1:0] pd;
        logic              seen;
        int                n;
        @(posedge core_clk);
        #1 pd = periph_div;
        @(posedge core_clk);
        #1 check({7'h0, pd[0] ^ periph_div[0]}, 8'h01, "fx/2 tap");
        pulse(0);
        check({6'h0, osc_run, cpu_run}, 8'h00, "stopped");
        pd = periph_div;
        seen = 1'b0;
        repeat (6) begin
            @(posedge core_clk);
            #1 seen = seen | cpu_tick;
        end
        check({7'h0, seen}, 8'h00, "no ticks");
        check(8'(periph_div), 8'(pd), "divider frozen");
        pulse(2);
        check({7'h0, osc_run}, 8'h01, "osc restarts");
        wait_run(n);
        check(8'(n >= STAB - 1 && n <= STAB + 2), 8'h01, "wake wait");
    endtask

    // Halt suspends only the CPU.
    task automatic t_halt;
        int n;
        pulse(1);
        check({6'h0, osc_run, cpu_run}, 8'h02, "halted");
        next_tick(n);
        check(8'(n), 8'h01, "halt ticks");
        pulse(2);
        check({7'h0, cpu_run}, 8'h01, "halt wake");
    endtask

    // Main sequence, with a reset in mid-run followed by a second pass of the register checks.
    initial begin
        {reg_wr, reg_rd, stop_req, halt_req, wake_req} = 5'h00;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        do_reset();
        t_regs();
        t_select();
        t_stop();
        t_halt();
        wr(CLOCK_DOUBLER_CONTROL_ADDR, 8'h01);
        wr(CPU_CLOCK_CONTROL_ADDR, 8'h00);
        do_reset();
        t_regs();
        final_report();
    end

    // Watchdog cuts a hang short.
    initial begin
        #(50 * 5000);
        num_errors++;
        $display("unexpected at %0t: timeout", $time);
        final_report();
    end
endmodule
